/* core/pswc_pkg.sv */
// constants, types and register map of the power-state and wake-up block
package pswc_pkg;
  localparam int CNT_W = 12;
  localparam logic [15:0] OFS_WAKE_SRC = 16'h0408;
  localparam logic [15:0] OFS_WAKE_MSK = 16'h040c;
  localparam logic [15:0] OFS_GPIO_CHG = 16'h0410;
  localparam logic [15:0] OFS_PWR_CTL  = 16'h0414;
  localparam logic [15:0] OFS_PWR_STAT = 16'h0418;
  localparam logic [15:0] OFS_IRQ_STAT = 16'h041c;
  localparam logic [15:0] OFS_IRQ_CLR  = 16'h0420;
  localparam logic [15:0] OFS_IRQ_EN   = 16'h0424;
  localparam logic [15:0] OFS_RISE_MSK = 16'h0428;
  localparam logic [15:0] OFS_FALL_MSK = 16'h042c;
  // wake source flag positions
  localparam int WS_TICK   = 0;
  localparam int WS_BUSY   = 1;
  localparam int WS_GPIO   = 2;
  localparam int WS_RESUME = 3;
  localparam logic [7:0]  RST_WAKE_SRC = 8'h00;
  localparam logic [7:0]  RST_WAKE_MSK = 8'hff;
  localparam logic [7:0]  MSK_FIXED    = 8'hf2;
  localparam logic [31:0] RST_GPIO_CHG = 32'h00000000;
  localparam logic [31:0] RST_EDGE_MSK = 32'hffffffff;
  localparam logic [2:0]  RST_IRQ      = 3'h0;
  // power control and status fields
  localparam int PWR_TGT_LSB = 0;
  localparam int STAT_BUSY   = 2;
  localparam int STAT_PLL_OK = 3;
  // interrupt status bits
  localparam int IRQ_WAKE  = 0;
  localparam int IRQ_STATE = 1;
  localparam int IRQ_GPIO  = 2;
  localparam int IRQ_W     = 3;
  // timing
  localparam int CLK_NS       = 8;
  localparam int SHUTDOWN_NS  = 400;
  localparam int OSC_START_NS = 2000;
  localparam int PLL_LOCK_NS  = 20000;
  localparam logic [CNT_W-1:0] SHUT_CNT =
    CNT_W'((SHUTDOWN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PLL_CNT =
    CNT_W'((PLL_LOCK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] OSC_PLL_CNT =
    CNT_W'((OSC_START_NS + PLL_LOCK_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    full_run_state, gated_run_state, low_clock_state, suspend_state
  } pswc_pstate_e;
  typedef enum logic [2:0] {
    FS_FULL, FS_GATED, FS_LOW, FS_SUSP, FS_SHUT, FS_SETTLE
  } pswc_fsm_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } pswc_bus_s;
  typedef struct packed {
    logic pll_en;
    logic rosc_en;
    logic unit_clk_en;
    logic gate_unused;
    logic cpu_clk_en;
  } pswc_clk_s;
endpackage : pswc_pkg

/* core/pswc_sync.sv */
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module pswc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // keep old value while the last two stages disagree
  assign q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));
  assign o_q   = q_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end
endmodule : pswc_sync

/* core/pswc_gpio_cell.sv */
// one gpio line: edge detect, direction masks and sticky change flag
`timescale 1ns/1ps
module pswc_gpio_cell (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // line and controls
  input  wire logic i_lvl,
  input  wire logic i_rise_msk,
  input  wire logic i_fall_msk,
  input  wire logic i_clr,
  // results
  output logic      o_flag,
  output logic      o_edge
);
  logic prev_r;
  logic flag_r;
  logic edge_r;
  logic rise;
  logic fall;
  logic set;
  logic flag_nxt;

  assign rise     = i_lvl & ~prev_r;
  assign fall     = ~i_lvl & prev_r;
  assign set      = (rise & ~i_rise_msk) | (fall & ~i_fall_msk);
  assign flag_nxt = set | (flag_r & ~i_clr);
  assign o_flag   = flag_r;
  assign o_edge   = edge_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_r <= 1'b0;
      flag_r <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      prev_r <= i_lvl;
      flag_r <= flag_nxt;
      edge_r <= rise | fall;
    end
  end
endmodule : pswc_gpio_cell

/* core/pswc_top.sv */
// power-state sequencer, wake sources and gpio change register
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module pswc_top
  import pswc_pkg::*;
#(
  parameter int GPIO_W = 32
) (
  // clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST_N,
  // register port
  input  wire pswc_bus_s         I_BUS,
  output logic      [31:0]       O_RDATA,
  // wake sources and status inputs
  input  wire logic [GPIO_W-1:0] I_GPIO,
  input  wire logic              I_USB_J,
  input  wire logic              I_USB_SUSPEND,
  input  wire logic              I_PLL_LOCK,
  input  wire logic              I_TIMER_IRQ,
  input  wire logic              I_CPU_SLEEP,
  // clock control
  output pswc_clk_s              O_CLK,
  output pswc_pstate_e           O_PWR_STATE,
  // interrupts and wake
  output logic                   O_WAKE_CPU,
  output logic                   O_GPIO_IRQ,
  output logic                   O_IRQ
);
  pswc_fsm_e           fsm_r;
  pswc_fsm_e           fsm_nxt;
  pswc_pstate_e        shut_tgt_r;
  pswc_pstate_e        shut_tgt_nxt;
  pswc_pstate_e        req_tgt;
  pswc_pstate_e        pstate;
  pswc_pstate_e        pstate_r;
  pswc_clk_s           clk_nxt;
  pswc_clk_s           clk_r;
  logic [CNT_W-1:0]    cnt_r;
  logic [CNT_W-1:0]    cnt_nxt;
  logic [GPIO_W+1:0]   pin_s;
  logic [GPIO_W-1:0]   gpio_s;
  logic [GPIO_W-1:0]   chg_flag;
  logic [GPIO_W-1:0]   chg_edge;
  logic [GPIO_W-1:0]   chg_clr;
  logic [GPIO_W-1:0]   rise_msk_r;
  logic [GPIO_W-1:0]   fall_msk_r;
  logic                j_s;
  logic                j_prev_r;
  logic                pll_lock_s;
  logic                tick_r;
  logic                resume_r;
  logic                tick_nxt;
  logic                resume_nxt;
  logic [7:0]          msk_r;
  logic [3:0]          flags;
  logic [3:0]          unmask;
  logic                gpio_sum;
  logic                gsum_prev_r;
  logic                busy;
  logic                wake_any;
  logic                wake_susp;
  logic                resume_ev;
  logic                pll_ok;
  logic [IRQ_W-1:0]    irq_ev;
  logic [IRQ_W-1:0]    irq_stat_r;
  logic [IRQ_W-1:0]    irq_en_r;
  logic [IRQ_W-1:0]    irq_nxt;
  logic                irq_r;
  logic                wake_r;
  logic                gpio_irq_r;
  logic [2:0]          warm_r;
  logic [31:0]         rdata_r;
  logic [31:0]         rd_val;
  logic [7:0]          src_rd;
  logic [31:0]         stat_rd;
  logic                wr_src;
  logic                wr_msk;
  logic                wr_chg;
  logic                wr_pwr;
  logic                wr_clr;
  logic                wr_en;
  logic                wr_rise;
  logic                wr_fall;

  // address decode
  assign wr_src  = I_BUS.we && (I_BUS.addr == OFS_WAKE_SRC);
  assign wr_msk  = I_BUS.we && (I_BUS.addr == OFS_WAKE_MSK);
  assign wr_chg  = I_BUS.we && (I_BUS.addr == OFS_GPIO_CHG);
  assign wr_pwr  = I_BUS.we && (I_BUS.addr == OFS_PWR_CTL);
  assign wr_clr  = I_BUS.we && (I_BUS.addr == OFS_IRQ_CLR);
  assign wr_en   = I_BUS.we && (I_BUS.addr == OFS_IRQ_EN);
  assign wr_rise = I_BUS.we && (I_BUS.addr == OFS_RISE_MSK);
  assign wr_fall = I_BUS.we && (I_BUS.addr == OFS_FALL_MSK);
  assign req_tgt = pswc_pstate_e'(I_BUS.wdata[PWR_TGT_LSB +: 2]);

  // pins from outside the clock domain
  pswc_sync #(.W(GPIO_W + 2)) u_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_d     ({I_PLL_LOCK, I_USB_J, I_GPIO}),
    .o_q     (pin_s)
  );
  assign gpio_s     = pin_s[GPIO_W-1:0];
  assign j_s        = pin_s[GPIO_W];
  assign pll_lock_s = pin_s[GPIO_W+1];

  // change register sits outside the vectored irq unit
  assign chg_clr = I_BUS.wdata[GPIO_W-1:0] & {GPIO_W{wr_chg}};
  for (genvar g = 0; g < GPIO_W; g++) begin : g_line
    pswc_gpio_cell u_cell (
      .i_clk      (I_CLK),
      .i_rst_n    (I_RST_N),
      .i_lvl      (gpio_s[g]),
      .i_rise_msk (rise_msk_r[g]),
      .i_fall_msk (fall_msk_r[g]),
      .i_clr      (chg_clr[g]),
      .o_flag     (chg_flag[g]),
      .o_edge     (chg_edge[g])
    );
  end

  // wake sources
  assign gpio_sum   = |chg_flag;
  assign resume_ev  = I_USB_SUSPEND && j_prev_r && !j_s;
  assign busy       = (fsm_r == FS_SHUT) || (fsm_r == FS_SETTLE);
  assign tick_nxt   = I_TIMER_IRQ |
                      (tick_r & ~(wr_src & I_BUS.wdata[WS_TICK]));
  assign resume_nxt = resume_ev |
                      (resume_r & ~(wr_src & I_BUS.wdata[WS_RESUME]));
  assign flags      = {resume_r, gpio_sum, busy, tick_r};
  // busy sits under a mask bit that is stuck at one
  assign unmask     = flags & ~msk_r[3:0];
  assign wake_any   = |unmask;
  // clocks are stopped in suspend, so the timer cannot wake it
  assign wake_susp  = unmask[WS_RESUME] | unmask[WS_GPIO];

  // power sequencer
  always_comb begin
    fsm_nxt      = fsm_r;
    shut_tgt_nxt = shut_tgt_r;
    cnt_nxt      = (cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;
    case (fsm_r)
      FS_FULL, FS_GATED: begin
        // wake events are ignored here; firmware alone moves on
        if (wr_pwr) begin
          if (req_tgt == low_clock_state || req_tgt == suspend_state) begin
            fsm_nxt      = FS_SHUT;
            cnt_nxt      = SHUT_CNT;
            shut_tgt_nxt = req_tgt;
          end else if (req_tgt == gated_run_state) begin
            fsm_nxt = FS_GATED;
          end else begin
            fsm_nxt = FS_FULL;
          end
        end
      end
      FS_SHUT: begin
        if (cnt_r == '0) begin
          fsm_nxt = (shut_tgt_r == suspend_state) ? FS_SUSP : FS_LOW;
        end
      end
      FS_LOW: begin
        if (wake_any) begin
          fsm_nxt = FS_SETTLE;
          cnt_nxt = PLL_CNT;
        end
      end
      FS_SUSP: begin
        if (wake_susp) begin
          fsm_nxt = FS_SETTLE;
          cnt_nxt = OSC_PLL_CNT;
        end
      end
      FS_SETTLE: begin
        // wait for both the timer and the lock pin
        if (cnt_r == '0 && pll_lock_s) begin
          fsm_nxt = FS_GATED;
        end
      end
      default: fsm_nxt = FS_FULL;
    endcase
  end

  // clock controls from the sequencer state
  assign clk_nxt.pll_en      = (fsm_r == FS_FULL) || (fsm_r == FS_GATED) ||
                               (fsm_r == FS_SETTLE);
  assign clk_nxt.rosc_en     = (fsm_r != FS_SUSP) &&
                               !(fsm_r == FS_SHUT &&
                                 shut_tgt_r == suspend_state);
  assign clk_nxt.unit_clk_en = (fsm_r == FS_FULL) || (fsm_r == FS_GATED) ||
                               (fsm_r == FS_LOW);
  assign clk_nxt.gate_unused = (fsm_r == FS_GATED) || (fsm_r == FS_LOW);
  assign clk_nxt.cpu_clk_en  = (fsm_r == FS_FULL) ||
                               (((fsm_r == FS_GATED) || (fsm_r == FS_LOW)) &&
                                (!I_CPU_SLEEP || wake_any));
  assign pstate = (fsm_r == FS_FULL) ? full_run_state :
                  (fsm_r == FS_LOW)  ? low_clock_state :
                  (fsm_r == FS_SUSP) ? suspend_state :
                  (fsm_r == FS_SHUT) ? shut_tgt_r : gated_run_state;
  assign pll_ok = pll_lock_s && clk_r.pll_en;

  // interrupt events; busy is deliberately not among them
  assign irq_ev[IRQ_WAKE]  = (fsm_r == FS_SETTLE) && (fsm_nxt == FS_GATED);
  assign irq_ev[IRQ_STATE] = (fsm_r == FS_SHUT) && (fsm_nxt != FS_SHUT);
  assign irq_ev[IRQ_GPIO]  = gpio_sum && !gsum_prev_r;
  assign irq_nxt = irq_ev |
                   (irq_stat_r & ~(I_BUS.wdata[IRQ_W-1:0] & {IRQ_W{wr_clr}}));

  // read mux
  assign src_rd  = {4'h0, flags};
  assign stat_rd = {28'h0000000, pll_ok, busy, pstate};
  assign rd_val  =
    (I_BUS.addr == OFS_WAKE_SRC) ? {24'h000000, src_rd} :
    (I_BUS.addr == OFS_WAKE_MSK) ? {24'h000000, msk_r} :
    (I_BUS.addr == OFS_GPIO_CHG) ? 32'(chg_flag) :
    (I_BUS.addr == OFS_PWR_STAT) ? stat_rd :
    (I_BUS.addr == OFS_IRQ_STAT) ? 32'(irq_stat_r) :
    (I_BUS.addr == OFS_IRQ_EN)   ? 32'(irq_en_r) :
    (I_BUS.addr == OFS_RISE_MSK) ? 32'(rise_msk_r) :
    (I_BUS.addr == OFS_FALL_MSK) ? 32'(fall_msk_r) : 32'h00000000;

  // hardware reset lands in full-run
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fsm_r      <= FS_FULL;
      shut_tgt_r <= full_run_state;
      cnt_r      <= '0;
      pstate_r   <= full_run_state;
      clk_r      <= 5'h1d;
    end else begin
      fsm_r      <= fsm_nxt;
      shut_tgt_r <= shut_tgt_nxt;
      cnt_r      <= cnt_nxt;
      pstate_r   <= pstate;
      clk_r      <= clk_nxt;
    end
  end

  // register file
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_r      <= RST_WAKE_SRC[WS_TICK];
      resume_r    <= RST_WAKE_SRC[WS_RESUME];
      msk_r       <= RST_WAKE_MSK;
      rise_msk_r  <= GPIO_W'(RST_EDGE_MSK);
      fall_msk_r  <= GPIO_W'(RST_EDGE_MSK);
      irq_stat_r  <= RST_IRQ;
      irq_en_r    <= RST_IRQ;
      j_prev_r    <= 1'b0;
      gsum_prev_r <= 1'b0;
    end else begin
      tick_r      <= tick_nxt;
      resume_r    <= resume_nxt;
      irq_stat_r  <= irq_nxt;
      j_prev_r    <= j_s;
      gsum_prev_r <= gpio_sum;
      if (wr_msk) begin
        msk_r <= I_BUS.wdata[7:0] | MSK_FIXED;
      end
      if (wr_rise) begin
        rise_msk_r <= I_BUS.wdata[GPIO_W-1:0];
      end
      if (wr_fall) begin
        fall_msk_r <= I_BUS.wdata[GPIO_W-1:0];
      end
      if (wr_en) begin
        irq_en_r <= I_BUS.wdata[IRQ_W-1:0];
      end
    end
  end

  // registered outputs
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_r    <= 32'h00000000;
      irq_r      <= 1'b0;
      wake_r     <= 1'b0;
      gpio_irq_r <= 1'b0;
      warm_r     <= 3'h0;
    end else begin
      rdata_r    <= I_BUS.re ? rd_val : 32'h00000000;
      irq_r      <= |(irq_stat_r & irq_en_r);
      wake_r     <= wake_any;
      // synchronised pins climb to their level after reset; that is no edge
      warm_r     <= warm_r + 3'(warm_r != 3'h7);
      gpio_irq_r <= (|chg_edge) && (warm_r == 3'h7);
    end
  end

  assign O_RDATA     = rdata_r;
  assign O_CLK       = clk_r;
  assign O_PWR_STATE = pstate_r;
  assign O_WAKE_CPU  = wake_r;
  assign O_GPIO_IRQ  = gpio_irq_r;
  assign O_IRQ       = irq_r;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  a_full_wake_hold:
    assert property (fsm_r == FS_FULL && !wr_pwr |=> fsm_r == FS_FULL)
    else $error("full-run left without firmware");
  a_gated_fw_only:
    assert property (fsm_r == FS_GATED && !wr_pwr |=> fsm_r == FS_GATED)
    else $error("gated-run left without firmware");
  a_low_wake_pll:
    assert property (fsm_r == FS_LOW && wake_any
                     |=> fsm_r == FS_SETTLE ##1 O_CLK.pll_en)
    else $error("low-clock wake did not restart pll");
  a_susp_clocks_off:
    assert property (fsm_r == FS_SUSP |=> !O_CLK.pll_en && !O_CLK.rosc_en)
    else $error("oscillators running in suspend");
  a_susp_timer_only:
    assert property (fsm_r == FS_SUSP && !unmask[WS_RESUME] &&
                     !unmask[WS_GPIO] |=> fsm_r == FS_SUSP)
    else $error("suspend left without gpio or resume");
  a_resume_flag_set:
    assert property (resume_ev |=> resume_r && src_rd[7:4] == 4'h0)
    else $error("resume flag not set");
  a_gpio_summary:
    assert property (I_BUS.re && I_BUS.addr == OFS_WAKE_SRC
                     |=> O_RDATA[WS_GPIO] == $past(chg_flag != '0))
    else $error("gpio summary disagrees with change register");
  a_busy_no_irq:
    assert property ($rose(busy) |=> !irq_stat_r[IRQ_WAKE] ||
                     $past(irq_stat_r[IRQ_WAKE]))
    else $error("busy raised an interrupt");
  a_resume_w1c:
    assert property (wr_src && I_BUS.wdata[WS_RESUME] && !resume_ev
                     |=> !resume_r)
    else $error("resume flag not cleared by write one");
  a_mask_fixed_ones:
    assert property (msk_r[7:4] == 4'hf && msk_r[WS_BUSY])
    else $error("fixed mask bits not one");
  a_settle_units_off:
    assert property (fsm_r == FS_SETTLE |=> !O_CLK.unit_clk_en)
    else $error("units clocked while settling");
  a_reset_full_run:
    assert property ($rose(I_RST_N) |-> O_PWR_STATE == full_run_state)
    else $error("reset did not give full-run");
endmodule : pswc_top

/* verif/pswc_pll_model.sv */
// behavioural pll: lock rises a fixed time after enable, drops at once
`timescale 1ns/1ps
module pswc_pll_model #(
  parameter int LOCK_DLY = 40
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // pll control and status
  input  wire logic i_pll_en,
  output logic      o_lock
);
  int cnt_r;

  // lock is lost the moment the enable falls, no grace period
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= 0;
      o_lock <= 1'b0;
    end else if (!i_pll_en) begin
      cnt_r  <= 0;
      o_lock <= 1'b0;
    end else begin
      if (cnt_r < LOCK_DLY) cnt_r <= cnt_r + 1;
      o_lock <= (cnt_r >= LOCK_DLY);
    end
  end
endmodule : pswc_pll_model

/* verif/pswc_top_bench.sv */
// self-checking bench of the power-state and wake-up block
`timescale 1ns/1ps
module pswc_top_bench;
  import pswc_pkg::*;
  logic I_CLK, I_RST_N, I_USB_J, I_USB_SUSPEND, I_PLL_LOCK;
  logic I_TIMER_IRQ, I_CPU_SLEEP;
  pswc_bus_s    I_BUS;
  logic [31:0]  O_RDATA, I_GPIO, d;
  pswc_clk_s    O_CLK;
  pswc_pstate_e O_PWR_STATE;
  logic         O_WAKE_CPU, O_GPIO_IRQ, O_IRQ;
  int n_mismatch, n_tests, seed, pulses, waited, line;

  pswc_top u_pswc_top (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_BUS(I_BUS),
    .O_RDATA(O_RDATA), .I_GPIO(I_GPIO), .I_USB_J(I_USB_J),
    .I_USB_SUSPEND(I_USB_SUSPEND), .I_PLL_LOCK(I_PLL_LOCK),
    .I_TIMER_IRQ(I_TIMER_IRQ), .I_CPU_SLEEP(I_CPU_SLEEP), .O_CLK(O_CLK),
    .O_PWR_STATE(O_PWR_STATE), .O_WAKE_CPU(O_WAKE_CPU),
    .O_GPIO_IRQ(O_GPIO_IRQ), .O_IRQ(O_IRQ));
  pswc_pll_model u_pswc_pll_model (.i_clk(I_CLK), .i_rst_n(I_RST_N),
    .i_pll_en(O_CLK.pll_en), .o_lock(I_PLL_LOCK));

  initial begin
    I_CLK = 1'b0;
    forever #4 I_CLK = ~I_CLK;
  end

  always @(posedge I_CLK) if (O_GPIO_IRQ === 1'b1) pulses++;

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // reserved bits of the mask always read back as one
  function automatic logic [31:0] exp_msk(input logic [7:0] v);
    return {24'h0, v | MSK_FIXED};
  endfunction : exp_msk

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge I_CLK);
    I_BUS <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge I_CLK);
    I_BUS <= '0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge I_CLK);
    I_BUS <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge I_CLK);
    I_BUS <= '0;
    #1 v = O_RDATA;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge I_CLK);
  endtask : idle

  task automatic tick();
    @(posedge I_CLK);
    I_TIMER_IRQ <= 1'b1;
    @(posedge I_CLK);
    I_TIMER_IRQ <= 1'b0;
  endtask : tick

  // bounded wait until the block is back in gated-run with units clocked
  task automatic wait_gated();
    waited = 0;
    while (!(O_PWR_STATE === gated_run_state && O_CLK.unit_clk_en === 1'b1)
           && waited < 4000) begin
      @(posedge I_CLK);
      waited++;
    end
  endtask : wait_gated

  initial begin
    idle(12000);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    seed = 36018;
    I_RST_N = 1'b0;
    I_BUS = '0;
    I_GPIO = $random(seed);
    I_USB_J = 1'b1;
    I_USB_SUSPEND = 1'b0;
    I_TIMER_IRQ = 1'b0;
    I_CPU_SLEEP = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    pulses = 0;
    idle(10);
    I_RST_N <= 1'b1;
    idle(6);
    // reset values, reserved and unmapped places
    chk(32'(O_PWR_STATE), 32'(full_run_state));
    chk(32'(O_CLK.pll_en), 32'h1);
    rd(OFS_WAKE_SRC, d); chk(d, 32'h0);
    rd(OFS_WAKE_MSK, d); chk(d, 32'hff);
    rd(OFS_GPIO_CHG, d); chk(d, 32'h0);
    rd(16'h0500, d); chk(d, 32'h0);
    wr(OFS_WAKE_MSK, 32'h0); rd(OFS_WAKE_MSK, d);
    chk(d, exp_msk(8'h0));
    // timer flag: masked keeps cpu asleep, unmasked wakes it; full stays
    wr(OFS_WAKE_MSK, 32'hff);
    tick(); idle(2);
    rd(OFS_WAKE_SRC, d); chk(d & 32'h1, 32'h1);
    chk(32'(O_WAKE_CPU), 32'h0);
    wr(OFS_WAKE_MSK, 32'hfe); idle(2);
    chk(32'(O_WAKE_CPU), 32'h1);
    chk(32'(O_PWR_STATE), 32'(full_run_state));
    wr(OFS_WAKE_SRC, 32'h0); rd(OFS_WAKE_SRC, d);
    chk(d & 32'h1, 32'h1);
    wr(OFS_WAKE_SRC, 32'h1); rd(OFS_WAKE_SRC, d);
    chk(d & 32'h1, 32'h0);
    // gpio: random line, each direction mask, both masks, clearing
    line = $unsigned($random(seed)) % 32;
    wr(OFS_RISE_MSK, ~(32'h1 << line));
    I_GPIO[line] <= 1'b0; idle(8);
    wr(OFS_GPIO_CHG, 32'hffffffff); pulses = 0;
    I_GPIO[line] <= 1'b1; idle(8);
    rd(OFS_GPIO_CHG, d); chk(d, 32'h1 << line);
    chk(32'(pulses), 32'h1);
    rd(OFS_WAKE_SRC, d); chk(d & 32'h4, 32'h4);
    wr(OFS_GPIO_CHG, 32'h1 << line);
    I_GPIO[line] <= 1'b0; idle(8);
    rd(OFS_GPIO_CHG, d); chk(d, 32'h0);
    chk(32'(pulses), 32'h2);
    rd(OFS_WAKE_SRC, d); chk(d & 32'h4, 32'h0);
    wr(OFS_RISE_MSK, 32'hffffffff);
    wr(OFS_FALL_MSK, ~(32'h1 << line));
    I_GPIO[line] <= 1'b1; idle(8);
    rd(OFS_GPIO_CHG, d); chk(d, 32'h0);
    I_GPIO[line] <= 1'b0; idle(8);
    rd(OFS_GPIO_CHG, d); chk(d, 32'h1 << line);
    wr(OFS_GPIO_CHG, 32'h1 << line);
    wr(OFS_FALL_MSK, 32'hffffffff);
    I_GPIO[line] <= 1'b1; idle(8);
    rd(OFS_GPIO_CHG, d); chk(d, 32'h0);
    // shutdown into suspend, busy flag visible and not clearable
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_PWR_CTL, 32'h3);
    rd(OFS_WAKE_SRC, d); chk(d & 32'h2, 32'h2);
    wr(OFS_WAKE_SRC, 32'h2);
    rd(OFS_WAKE_SRC, d); chk(d & 32'h2, 32'h2);
    chk(32'(O_IRQ), 32'h0);
    idle(60);
    chk(32'(O_PWR_STATE), 32'(suspend_state));
    chk(32'({O_CLK.pll_en, O_CLK.rosc_en}), 32'h0);
    // unmasked timer is not a suspend wake cause
    tick(); idle(20);
    chk(32'(O_PWR_STATE), 32'(suspend_state));
    wr(OFS_WAKE_SRC, 32'h1);
    // usb resume: leave J while in global suspend
    wr(OFS_WAKE_MSK, 32'hf6);
    I_USB_SUSPEND <= 1'b1;
    idle(2);
    I_USB_J <= 1'b0;
    idle(10);
    chk(32'(O_CLK.unit_clk_en), 32'h0);
    chk(32'(O_CLK.pll_en), 32'h1);
    wait_gated();
    chk(32'(waited >= 32'(OSC_PLL_CNT) - 20), 32'h1);
    chk(32'(O_PWR_STATE), 32'(gated_run_state));
    idle(2);
    chk(32'(O_IRQ), 32'h1);
    rd(OFS_WAKE_SRC, d); chk(d & 32'hfa, 32'h8);
    rd(OFS_PWR_STAT, d); chk(d & 32'hc, 32'h8);
    wr(OFS_IRQ_CLR, 32'h7); idle(2);
    chk(32'(O_IRQ), 32'h0);
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_WAKE_SRC, 32'h8);
    I_USB_SUSPEND <= 1'b0;
    I_USB_J <= 1'b1;
    // gated-run sleep stops cpu clock, then low-clock and timer wake
    I_CPU_SLEEP <= 1'b1; idle(3);
    chk(32'(O_CLK.cpu_clk_en), 32'h0);
    chk(32'(O_CLK.gate_unused), 32'h1);
    I_CPU_SLEEP <= 1'b0;
    wr(OFS_PWR_CTL, 32'h2); idle(60);
    chk(32'(O_PWR_STATE), 32'(low_clock_state));
    chk(32'({O_CLK.pll_en, O_CLK.rosc_en}), 32'h1);
    rd(OFS_PWR_STAT, d); chk(d & 32'h8, 32'h0);
    tick(); idle(4);
    chk(32'(O_CLK.pll_en), 32'h1);
    wait_gated();
    chk(32'(O_PWR_STATE), 32'(gated_run_state));
    wr(OFS_WAKE_SRC, 32'h1);
    // firmware exit from gated-run, then reset in mid-run
    wr(OFS_PWR_CTL, 32'h0); idle(3);
    chk(32'(O_PWR_STATE), 32'(full_run_state));
    chk(32'(O_CLK.gate_unused), 32'h0);
    wr(OFS_PWR_CTL, 32'h1); idle(3);
    chk(32'(O_PWR_STATE), 32'(gated_run_state));
    tick(); idle(2);
    chk(32'(O_PWR_STATE), 32'(gated_run_state));
    @(posedge I_CLK);
    I_RST_N <= 1'b0;
    idle(2);
    I_RST_N <= 1'b1;
    idle(2);
    chk(32'(O_PWR_STATE), 32'(full_run_state));
    rd(OFS_WAKE_SRC, d); chk(d, 32'h0);
    report_and_stop();
  end
endmodule : pswc_top_bench
